/* verilog/qar_pkg.sv */
// qar_pkg: shared constants of the quad converter serial readout link
// assumes: both ends and the bench import this package
package qar_pkg;
  localparam int          QAR_LANES     = 4;
  localparam int          QAR_BITS      = 16;
  localparam int          QAR_CW        = 5;
  // 2-bit io standard code: cmos, lvds, low power lvds
  localparam logic [1:0]  QAR_IO_CMOS   = 2'h0;
  localparam logic [1:0]  QAR_IO_LVDS   = 2'h1;
  localparam logic [1:0]  QAR_IO_LPLVDS = 2'h2;
  // ahb register byte offsets of the controller
  localparam logic [7:0]  QAR_OFS_CTRL  = 8'h00;
  localparam logic [7:0]  QAR_OFS_STAT  = 8'h04;
  localparam logic [7:0]  QAR_OFS_DATA0 = 8'h08;
  localparam logic [7:0]  QAR_OFS_DATA1 = 8'h0c;
  // control and status fields
  localparam int          QAR_CTRL_GO   = 0;
  localparam int          QAR_CTRL_DDR  = 1;
  localparam int          QAR_CTRL_ECHO = 2;
  localparam int          QAR_CTRL_IO   = 4;
  localparam int          QAR_CTRL_REF  = 6;
  localparam int          QAR_STAT_BUSY = 0;
  localparam int          QAR_STAT_DONE = 1;
  localparam logic [31:0] QAR_CTRL_RST  = 32'h0000_0040;
  // shift clock divider: terminal count, half period is this plus one system cycles
  localparam logic [3:0]  QAR_HALF_DIV  = 4'h2;
  // link cycles of strobe-high acquisition and strobe-low conversion
  localparam logic [7:0]  QAR_ACQ_CYC   = 8'h04;
  localparam logic [7:0]  QAR_CONV_CYC  = 8'h04;
  // device-side test result seed and step per conversion
  localparam logic [15:0] QAR_SEED      = 16'h8001;
  localparam logic [15:0] QAR_STEP      = 16'h1357;
endpackage : qar_pkg

/* verilog/qar_link_if.sv */
// qar_link_if: pins between converter device and host controller
// assumes: no clocking block; bench joins the two modports
`timescale 1ns/1ps
interface qar_link_if;
  logic       convert_strobe_n;
  logic       shift_clk;
  logic       echo_clock_out;
  logic [3:0] lane;
  logic [3:0] lane_oe;
  logic       edge_rate_select;
  logic       echo_clock_disable;
  logic [1:0] io_standard;
  logic       ref_buffer_on;
  modport dev (input convert_strobe_n, shift_clk, edge_rate_select,
               echo_clock_disable, io_standard, ref_buffer_on,
               output echo_clock_out, lane, lane_oe);
  modport host (output convert_strobe_n, shift_clk, edge_rate_select,
                echo_clock_disable, io_standard, ref_buffer_on,
                input echo_clock_out, lane, lane_oe);
endinterface : qar_link_if

/* verilog/qar_lane_shift.sv */
// qar_lane_shift: one channel's 16-bit result shifter, msb first
// assumes: both shift-clock edges arrive; ddr chooses whether rising counts
`timescale 1ns/1ps
module qar_lane_shift
  import qar_pkg::*;
(
  input  wire logic                    shift_clk_in,
  input  wire logic                    convert_strobe_n_in,
  input  wire logic                    ddr_in,
  input  wire logic [QAR_BITS-1:0]     result_in,
  output logic                         bit_out
);
  logic [QAR_BITS-1:0] rise_r;
  logic [QAR_BITS-1:0] fall_r;
  logic                rise_cnt_r;
  logic [QAR_CW-1:0]   fall_cnt_r;
  // number of advances taken so far, on both edges in ddr
  logic [QAR_CW-1:0]   pos;

  // strobe high reloads, so strobe low starts at the msb
  always_ff @(posedge shift_clk_in or posedge convert_strobe_n_in)
    if (convert_strobe_n_in)
      rise_cnt_r <= 1'b0;
    else if (ddr_in)
      rise_cnt_r <= ~rise_cnt_r;
  always_ff @(negedge shift_clk_in or posedge convert_strobe_n_in)
    if (convert_strobe_n_in)
      fall_cnt_r <= '0;
    else
      fall_cnt_r <= fall_cnt_r + 5'h01;

  // position counts falls always, rises only in ddr
  always_comb
  begin
    pos = ddr_in ? QAR_CW'(fall_cnt_r * 2) : fall_cnt_r;
    if (ddr_in && rise_cnt_r != fall_cnt_r[0])
      pos = pos + 5'h01;
  end
  assign rise_r = result_in;
  assign fall_r = result_in;
  assign bit_out = (pos < QAR_CW'(QAR_BITS)) ?
                   rise_r[QAR_BITS-1-pos[3:0]] : 1'b0;
endmodule : qar_lane_shift

/* verilog/qar_device.sv */
// qar_device: converter readout logic, clocked by the link strobe fall and shift clock
// assumes: strobe rises between frames; straps are static
`timescale 1ns/1ps
module qar_device
  import qar_pkg::*;
(
  qar_link_if.dev              link,
  input  wire logic            sys_rst_in,
  output logic [1:0]           io_mode_out,
  output logic                 ref_buffers_enabled_out,
  output logic [QAR_LANES-1:0] converting_out
);
  typedef struct packed {
    logic [QAR_BITS-1:0] sample;
    logic [QAR_LANES*QAR_BITS-1:0] shown;
  } qar_dev_st_t;
  qar_dev_st_t st_r;
  qar_dev_st_t st_nxt;
  logic [QAR_LANES-1:0] lane_bit;

  // a conversion happens at the strobe fall; the previous sample is
  // what gets shifted, giving one cycle of latency
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sample = st_r.sample + QAR_STEP;
    for (int c = 0; c < QAR_LANES; c++)
      st_nxt.shown[c*QAR_BITS +: QAR_BITS] =
        st_r.sample ^ QAR_BITS'(c);
  end
  always_ff @(negedge link.convert_strobe_n or posedge sys_rst_in)
    if (sys_rst_in)
      st_r <= '{sample: QAR_SEED, shown: '0};
    else
      st_r <= st_nxt;

  // one shifter per channel, lane order follows channel order
  for (genvar c = 0; c < QAR_LANES; c++)
  begin : g_lane
    qar_lane_shift u_sh (
      .shift_clk_in        (link.shift_clk),
      .convert_strobe_n_in (link.convert_strobe_n),
      .ddr_in              (link.edge_rate_select),
      .result_in           (st_r.shown[c*QAR_BITS +: QAR_BITS]),
      .bit_out             (lane_bit[c])
    );
  end

  assign link.lane    = lane_bit;
  assign link.lane_oe = {QAR_LANES{~link.convert_strobe_n}};
  // echo gated by the disable strap
  assign link.echo_clock_out = link.shift_clk & ~link.echo_clock_disable;
  assign io_mode_out = link.io_standard;
  // input left open would read high through the pull-up
  assign ref_buffers_enabled_out = link.ref_buffer_on !== 1'b0;
  assign converting_out = {QAR_LANES{~link.convert_strobe_n}};
endmodule : qar_device

/* verilog/qar_host.sv */
// qar_host: ahb-lite controlled host that runs one frame per go
// assumes: single ahb slave; straps driven from control register
`timescale 1ns/1ps
module qar_host
  import qar_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  qar_link_if.host         link,
  input  wire logic        hsel_in,
  input  wire logic [7:0]  haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out
);
  // gray along idle, shift, conv, done
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_SHIFT = 2'b01,
                            H_CONV = 2'b11, H_DONE = 2'b10} qar_hst_t;
  typedef struct packed {
    qar_hst_t    state;
    logic [31:0] ctrl;
    logic        done;
    logic [3:0]  div;
    logic [5:0]  edges;
    logic        sck;
    logic        cnv_n;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
  } qar_host_st_t;
  qar_host_st_t st_r;
  qar_host_st_t st_nxt;
  logic [63:0] cap_r;
  logic [31:0] cap_rise_r;
  logic [63:0] cap_all;
  logic [3:0]  e1_r;
  logic [3:0]  e2_r;

  // host captures lanes with the echo clock, as the data align with it
  always_ff @(negedge link.echo_clock_out or posedge sys_rst_in)
    if (sys_rst_in)
      cap_r <= '0;
    else if (!link.convert_strobe_n)
      cap_r <= {cap_r[59:0], link.lane};
  // in ddr the even bits arrive before each echo rise
  always_ff @(posedge link.echo_clock_out or posedge sys_rst_in)
    if (sys_rst_in)
      cap_rise_r <= '0;
    else if (!link.convert_strobe_n && link.edge_rate_select)
      cap_rise_r <= {cap_rise_r[27:0], link.lane};
  // ddr interleaves rise and fall nibbles, first nibble on top
  always_comb
  begin
    cap_all = cap_r;
    if (st_r.ctrl[QAR_CTRL_DDR])
      for (int k = 0; k < 8; k++)
      begin
        cap_all[8*k+4 +: 4] = cap_rise_r[4*k +: 4];
        cap_all[8*k +: 4]   = cap_r[4*k +: 4];
      end
  end
  // echo clock is another domain; its level is synchronised through two flops
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      e1_r <= '0;
      e2_r <= '0;
    end
    else
    begin
      e1_r <= {3'h0, link.echo_clock_out};
      e2_r <= e1_r;
    end

  always_comb
  begin
    st_nxt = st_r;
    if (st_r.wr_pend && st_r.wr_addr == QAR_OFS_CTRL)
      st_nxt.ctrl = hwdata_in;
    st_nxt.wr_pend = hsel_in && hready_in && htrans_in[1] && hwrite_in;
    st_nxt.wr_addr = haddr_in;
    unique case (haddr_in)
      QAR_OFS_CTRL:  st_nxt.rdata = st_r.ctrl;
      QAR_OFS_STAT:  st_nxt.rdata = {30'h0, st_r.done,
                                     st_r.state != H_IDLE};
      QAR_OFS_DATA0: st_nxt.rdata = cap_all[31:0];
      QAR_OFS_DATA1: st_nxt.rdata = cap_all[63:32];
      default:       st_nxt.rdata = 32'h0;
    endcase
    st_nxt.div = st_r.div + 4'h1;
    unique case (st_r.state)
      H_IDLE:
        if (st_r.ctrl[QAR_CTRL_GO])
        begin
          st_nxt.ctrl[QAR_CTRL_GO] = 1'b0;
          st_nxt.done  = 1'b0;
          st_nxt.cnv_n = 1'b0;
          st_nxt.div   = '0;
          st_nxt.edges = '0;
          st_nxt.state = H_SHIFT;
        end
      H_SHIFT:
        if (st_r.div == QAR_HALF_DIV)
        begin
          st_nxt.div = '0;
          st_nxt.sck = ~st_r.sck;
          st_nxt.edges = st_r.edges + 6'h01;
          // 16 clock cycles in sdr, 8 in ddr
          if (st_r.edges == (st_r.ctrl[QAR_CTRL_DDR] ? 6'd15 : 6'd31))
            st_nxt.state = H_CONV;
        end
      H_CONV:
        if (st_r.div == QAR_HALF_DIV)
        begin
          st_nxt.cnv_n = 1'b1;
          st_nxt.state = H_DONE;
        end
      H_DONE:
      begin
        st_nxt.done  = 1'b1;
        st_nxt.state = H_IDLE;
      end
    endcase
  end
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
      st_r <= '{state: H_IDLE, ctrl: QAR_CTRL_RST, done: 1'b0,
                div: 4'h0, edges: 6'h00, sck: 1'b0, cnv_n: 1'b1,
                wr_pend: 1'b0, wr_addr: 8'h00, rdata: 32'h0};
    else
      st_r <= st_nxt;

  assign link.convert_strobe_n   = st_r.cnv_n;
  assign link.shift_clk          = st_r.sck;
  assign link.edge_rate_select   = st_r.ctrl[QAR_CTRL_DDR];
  assign link.echo_clock_disable = st_r.ctrl[QAR_CTRL_ECHO];
  assign link.io_standard        = st_r.ctrl[QAR_CTRL_IO +: 2];
  assign link.ref_buffer_on      = st_r.ctrl[QAR_CTRL_REF];
  assign hrdata_out    = st_r.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
endmodule : qar_host

/* bench/qar_link_assertions.sv */
// qar_link_assertions: link checks sampled on the system clock
// assumes: inputs wired by name to the link interface signals
`timescale 1ns/1ps
module qar_link_assertions (
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       convert_strobe_n,
  input  wire logic       shift_clk,
  input  wire logic       echo_clock_out,
  input  wire logic [3:0] lane,
  input  wire logic [3:0] lane_oe,
  input  wire logic       edge_rate_select,
  input  wire logic       echo_clock_disable,
  input  wire logic [1:0] io_standard
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  logic       sck_d_r;
  logic [4:0] rise_cnt_r;
  // shift clock rises per frame; cleared while the strobe is high
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sck_d_r    <= 1'b0;
      rise_cnt_r <= 5'h00;
    end
    else
    begin
      sck_d_r <= shift_clk;
      if (convert_strobe_n)
        rise_cnt_r <= 5'h00;
      else if (shift_clk && !sck_d_r)
        rise_cnt_r <= rise_cnt_r + 5'h01;
    end
  end
  frame_len_a: assert property ($rose(convert_strobe_n)
    |-> rise_cnt_r == (edge_rate_select ? 5'h08 : 5'h10))
    else $error("shift clock edge count per frame wrong");
  sck_idle_a: assert property (convert_strobe_n && $past(convert_strobe_n)
    |-> !shift_clk) else $error("shift clock moved in acquisition");
  lane_release_a: assert property (convert_strobe_n && $past(convert_strobe_n)
    |-> lane_oe == 4'h0) else $error("lanes driven with strobe high");
  lane_drive_a: assert property ($fell(convert_strobe_n)
    |-> ##[1:2] lane_oe == 4'hf) else $error("lanes not driven in frame");
  sdr_hold_a: assert property (!edge_rate_select && !convert_strobe_n
    && $rose(shift_clk) |-> $stable(lane)) else $error("lane moved on rise");
  echo_follow_a: assert property (!echo_clock_disable && $stable(shift_clk)
    |-> echo_clock_out == shift_clk) else $error("echo clock differs");
  echo_stop_a: assert property (echo_clock_disable && $past(echo_clock_disable)
    |-> $stable(echo_clock_out)) else $error("echo clock runs when off");
  strap_hold_a: assert property (!convert_strobe_n && $past(!convert_strobe_n)
    |-> $stable(io_standard) && $stable(edge_rate_select))
    else $error("straps moved in frame");
endmodule : qar_link_assertions

/* bench/testbench.sv */
// testbench: ahb master drives the host, which reads the device link
// assumes: zero-wait slave; host makes the shift clock from mclk_in
`timescale 1ns/1ps
module testbench;
  import qar_pkg::*;
  logic        mclk_in, sys_rst_in, hsel, hwrite, hrdy, hresp, ref_on;
  logic [7:0]  haddr;
  logic [1:0]  htrans, io_mode;
  logic [2:0]  hsize;
  logic [3:0]  conv;
  logic [31:0] hwdata, hrdata, rd, d0, d1;
  logic [15:0] w [3];
  logic [1:0]  io_tab [3] = '{QAR_IO_CMOS, QAR_IO_LVDS, QAR_IO_LPLVDS};
  int          n_mismatch, check_count;
  qar_link_if link ();
  qar_host qar_host_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .link(link.host), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
    .hresp_out(hresp));
  qar_device qar_device_inst (.link(link.dev), .sys_rst_in(sys_rst_in),
    .io_mode_out(io_mode), .ref_buffers_enabled_out(ref_on),
    .converting_out(conv));
  qar_link_assertions qar_link_assertions_inst (.mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in), .convert_strobe_n(link.convert_strobe_n),
    .shift_clk(link.shift_clk), .echo_clock_out(link.echo_clock_out),
    .lane(link.lane), .lane_oe(link.lane_oe),
    .edge_rate_select(link.edge_rate_select),
    .echo_clock_disable(link.echo_clock_disable),
    .io_standard(link.io_standard));
  // free-running system clock, 100 ns period
  always #50 mclk_in = ~mclk_in;
  task conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // bounded wait for hready at a rising edge; a hang ends the run
  task wait_rdy;
    int i;
    i = 0;
    do
    begin
      @(posedge mclk_in);
      i++;
    end
    while (hrdy !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      n_mismatch++;
      conclude();
    end
  endtask : wait_rdy
  // one whole-word single transfer; entered just after a rising edge
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : xfer
  task poll(input int b, input logic v);
    int i;
    i = 0;
    do
    begin
      xfer(1'b0, QAR_OFS_STAT, 32'h0);
      i++;
    end
    while (rd[b] !== v && i < 200);
    check(32'(rd[b]), 32'(v));
  endtask : poll
  // start a frame, wait for it, fetch the 64 captured lane bits
  task frame(input logic [31:0] ctrl);
    xfer(1'b1, QAR_OFS_CTRL, ctrl | 32'h1);
    poll(QAR_STAT_BUSY, 1'b1);
    poll(QAR_STAT_BUSY, 1'b0);
    check(32'(rd[QAR_STAT_DONE]), 32'h1);
    xfer(1'b0, QAR_OFS_DATA0, 32'h0);
    d0 = rd;
    xfer(1'b0, QAR_OFS_DATA1, 32'h0);
    d1 = rd;
  endtask : frame
  // channel c from the nibble stream, first nibble is the msb
  function logic [15:0] chan(input int c);
    logic [63:0] v;
    v = {d1, d0};
    for (int i = 0; i < 16; i++)
      chan[15-i] = v[60-4*i+c];
  endfunction : chan
  initial
  begin
    mclk_in = 1'b0;
    sys_rst_in = 1'b1;
    hsel = 1'b1;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    n_mismatch = 0;
    check_count = 0;
    repeat (3) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    xfer(1'b0, QAR_OFS_CTRL, 32'h0);
    check(rd, QAR_CTRL_RST);
    check(32'(ref_on), 32'h1);
    xfer(1'b1, 8'h10, 32'hffff_ffff);
    xfer(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    $display("test reset and unmapped done");
    // the first frame after reset carries no earlier conversion
    for (int f = 0; f < 3; f++)
    begin
      frame(QAR_CTRL_RST);
      w[f] = chan(0);
      for (int c = 1; c < 4; c++)
        check(32'(chan(c)), 32'(w[f] ^ 16'(c)));
    end
    check(32'(w[0]), 32'(QAR_SEED));
    check(32'(w[2]), 32'(w[1] + QAR_STEP));
    $display("test sdr frames done");
    // ddr, reference buffers off, every io standard; echo off last
    for (int m = 0; m < 3; m++)
    begin
      frame({26'h0, io_tab[m], 1'b0, (m == 2), 2'h2});
      if (m < 2)
        for (int c = 0; c < 4; c++)
          check(32'(chan(c)),
                32'((QAR_SEED + 16'(3 + m) * QAR_STEP) ^ 16'(c)));
      check(32'(io_mode), 32'(io_tab[m]));
      check(32'(ref_on), 32'h0);
    end
    $display("test ddr modes done");
    conclude();
  end
endmodule : testbench
